/* File: hdl/ser_top.sv */
// status event registers: four status sets, condition registers and query port
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"

module ser_top
	import ser_pkg::*;
#(
	parameter int BUF_CNT_W = 12
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// query command port
	input  wire logic                 cmd_valid,
	input  wire ser_op_t              cmd_op,
	input  wire ser_set_sel_t         cmd_set,
	input  wire logic [15:0]          cmd_data,
	// query response
	output logic                      resp_valid,
	output logic [15:0]               resp_data,
	// standard event sources
	input  wire logic                 ops_pending,
	input  wire logic                 talk_read,
	input  wire logic                 out_queue_empty,
	input  wire logic                 internal_fault,
	input  wire logic                 execution_fault,
	input  wire logic                 syntax_fault,
	input  wire logic                 semantic_fault,
	input  wire logic                 trigger_in_message,
	input  wire logic                 local_key_pin,
	// operation conditions
	input  wire logic                 cal_busy,
	input  wire logic                 sweep_active,
	input  wire logic                 wait_trigger,
	input  wire logic                 wait_arm,
	input  wire logic                 idle_state,
	// measurement conditions
	input  wire logic                 limit_one_fail,
	input  wire logic                 lower_bound_two_fail,
	input  wire logic                 upper_bound_two_fail,
	input  wire logic                 lower_bound_three_fail,
	input  wire logic                 upper_bound_three_fail,
	input  wire logic                 limits_all_pass,
	input  wire logic                 reading_ready,
	input  wire logic                 range_exceeded,
	input  wire logic [BUF_CNT_W-1:0] buffer_count,
	input  wire logic                 trace_store_full,
	input  wire logic                 contact_check_fail,
	input  wire logic                 interlock_n_pin,
	input  wire logic                 thermal_fault,
	input  wire logic                 source_limited,
	input  wire logic                 source_clamped,
	// questionable sources
	input  wire logic                 cal_check_fail,
	input  wire logic                 cal_done_ok,
	input  wire logic                 ignored_parameter_notice,
	// summaries and source gate
	output logic [3:0]                summary,
	output logic                      source_on_permit
);

	ser_top_state_t state_reg;
	ser_top_state_t state_next;

	logic [15:0] set_cond    [4];
	logic [15:0] set_evt     [4];
	logic [15:0] set_events  [4];
	logic [15:0] set_enables [4];
	logic [3:0]  set_rd_clr;
	logic [3:0]  set_en_wr;
	logic        do_clear;
	logic        do_preset;
	logic        opc_fire;
	logic        key_press;
	logic        opc_query;
	logic        read_now;
	logic        buf_two;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [15:0] ser_used_mask(input int idx);
		case (idx)
			0:       ser_used_mask = `SER_STD_USED_MASK;
			1:       ser_used_mask = `SER_OPER_USED_MASK;
			2:       ser_used_mask = `SER_MEAS_USED_MASK;
			default: ser_used_mask = `SER_QUES_USED_MASK;
		endcase
	endfunction : ser_used_mask

	function automatic logic ser_cmd_is(input logic valid, input ser_op_t op,
		input ser_op_t want);
		ser_cmd_is = valid && (op == want);
	endfunction : ser_cmd_is

	function automatic logic ser_hit(input logic valid, input ser_op_t op,
		input ser_set_sel_t sel, input ser_op_t want, input int idx);
		ser_hit = ser_cmd_is(valid, op, want) && (int'(sel) == idx);
	endfunction : ser_hit

	// read commands of any kind share one answer path
	function automatic logic ser_is_read(input logic valid, input ser_op_t op);
		ser_is_read = ser_cmd_is(valid, op, SER_OP_READ_EVT)
			|| ser_cmd_is(valid, op, SER_OP_READ_COND)
			|| ser_cmd_is(valid, op, SER_OP_READ_EN);
	endfunction : ser_is_read

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	assign do_clear  = ser_cmd_is(cmd_valid, cmd_op, SER_OP_CLEAR);
	assign do_preset = ser_cmd_is(cmd_valid, cmd_op, SER_OP_PRESET);
	assign opc_query = ser_cmd_is(cmd_valid, cmd_op, SER_OP_OPC_QUERY);
	assign read_now  = ser_is_read(cmd_valid, cmd_op);
	// a read owns the answer slot, so a due completion answer waits a cycle
	assign opc_fire  = state_reg.opc_armed && !ops_pending && !read_now;
	assign key_press = state_reg.key_sync && !state_reg.key_prev;

	// ----------------------------------------
	// event sources per set
	// ----------------------------------------
	always_comb begin
		set_evt[0] = 16'h0000;
		set_evt[0][`SER_STD_OPC_BIT]   = opc_fire;
		set_evt[0][`SER_STD_EMPTY_BIT] = talk_read && out_queue_empty;
		set_evt[0][`SER_STD_INTF_BIT]  = internal_fault;
		set_evt[0][`SER_STD_EXEF_BIT]  = execution_fault;
		set_evt[0][`SER_STD_CMDF_BIT]  = syntax_fault || semantic_fault
			|| trigger_in_message;
		set_evt[0][`SER_STD_LKEY_BIT]  = key_press;
		set_evt[0][`SER_STD_PWR_BIT]   = state_reg.pon_pending;
		set_evt[1] = 16'h0000;
		set_evt[2] = 16'h0000;
		set_evt[3] = 16'h0000;
		set_evt[3][`SER_QUES_WARN_BIT] = ignored_parameter_notice;
		// the standard set has no condition register
		set_cond[0] = 16'h0000;
		set_cond[1] = state_reg.oper_cond;
		set_cond[2] = state_reg.meas_cond;
		set_cond[3] = state_reg.ques_cond;
	end

	// ----------------------------------------
	// the four register sets
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_set
			assign set_rd_clr[gi] = ser_hit(cmd_valid, cmd_op, cmd_set, SER_OP_READ_EVT, gi);
			assign set_en_wr[gi]  = ser_hit(cmd_valid, cmd_op, cmd_set, SER_OP_WRITE_EN, gi);
			ser_set #(
				.USED_MASK(ser_used_mask(gi))
			) u_set (
				.clock       (clock),
				.rst         (rst),
				.cond        (set_cond[gi]),
				.evt         (set_evt[gi]),
				.read_clr    (set_rd_clr[gi]),
				.clear_status(do_clear),
				.preset      (do_preset),
				.enable_wr   (set_en_wr[gi]),
				.enable_data (cmd_data),
				.event_bits  (set_events[gi]),
				.enable_bits (set_enables[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// buffer level
	// ----------------------------------------
	// a count too narrow to hold two can never report two readings
	generate
		if (BUF_CNT_W > 1) begin : g_buf_wide
			assign buf_two = (buffer_count >= BUF_CNT_W'(`SER_BUF_TWO));
		end else begin : g_buf_narrow
			assign buf_two = 1'b0;
		end
	endgenerate

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next             = state_reg;
		// pin inputs pass two flops before anything reads them
		state_next.intlk_meta  = interlock_n_pin;
		state_next.intlk_sync  = state_reg.intlk_meta;
		state_next.key_meta    = local_key_pin;
		state_next.key_sync    = state_reg.key_meta;
		state_next.key_prev    = state_reg.key_sync;
		state_next.pon_pending = 1'b0;
		// the answer strobe stands one cycle
		state_next.resp_valid  = 1'b0;

		// completion query waits until nothing is pending
		if (opc_fire) begin
			state_next.opc_armed = 1'b0;
		end
		if (opc_query) begin
			state_next.opc_armed = 1'b1;
		end

		// calibration fault holds until a good calibration; a new fault wins
		if (cal_done_ok) begin
			state_next.cal_invalid = 1'b0;
		end
		if (cal_check_fail) begin
			state_next.cal_invalid = 1'b1;
		end

		// condition registers follow the live levels
		state_next.oper_cond = 16'h0000;
		state_next.oper_cond[`SER_OPER_CAL_BIT]   = cal_busy;
		state_next.oper_cond[`SER_OPER_SWEEP_BIT] = sweep_active;
		state_next.oper_cond[`SER_OPER_TRIG_BIT]  = wait_trigger;
		state_next.oper_cond[`SER_OPER_ARM_BIT]   = wait_arm;
		state_next.oper_cond[`SER_OPER_IDLE_BIT]  = idle_state;

		state_next.meas_cond = 16'h0000;
		state_next.meas_cond[`SER_MEAS_LIM1_BIT]  = limit_one_fail;
		state_next.meas_cond[`SER_MEAS_LL2_BIT]   = lower_bound_two_fail;
		state_next.meas_cond[`SER_MEAS_HL2_BIT]   = upper_bound_two_fail;
		state_next.meas_cond[`SER_MEAS_LL3_BIT]   = lower_bound_three_fail;
		state_next.meas_cond[`SER_MEAS_HL3_BIT]   = upper_bound_three_fail;
		state_next.meas_cond[`SER_MEAS_PASS_BIT]  = limits_all_pass;
		state_next.meas_cond[`SER_MEAS_RDY_BIT]   = reading_ready;
		state_next.meas_cond[`SER_MEAS_RANGE_BIT] = range_exceeded;
		state_next.meas_cond[`SER_MEAS_BUF2_BIT]  = buf_two;
		state_next.meas_cond[`SER_MEAS_FULL_BIT]  = trace_store_full;
		state_next.meas_cond[`SER_MEAS_CONT_BIT]  = contact_check_fail;
		state_next.meas_cond[`SER_MEAS_SAFE_BIT]  = !state_reg.intlk_sync;
		state_next.meas_cond[`SER_MEAS_THERM_BIT] = thermal_fault;
		state_next.meas_cond[`SER_MEAS_SLIM_BIT]  = source_limited;
		state_next.meas_cond[`SER_MEAS_CLAMP_BIT] = source_clamped;

		state_next.ques_cond = 16'h0000;
		state_next.ques_cond[`SER_QUES_CAL_BIT] = state_reg.cal_invalid;

		// output may turn on only with interlock closed and no overheating
		state_next.source_permit = !state_reg.intlk_sync && !thermal_fault;

		// summaries are registered, so they trail the event bits by one cycle
		for (int i = 0; i < 4; i++) begin
			state_next.summary[i] = |(set_events[i] & set_enables[i]);
		end

		// query answers; the read returns the contents before the clear
		if (cmd_valid) begin
			unique case (cmd_op)
				SER_OP_READ_EVT: begin
					state_next.resp_valid = 1'b1;
					state_next.resp_data  = set_events[cmd_set];
				end
				SER_OP_READ_COND: begin
					state_next.resp_valid = 1'b1;
					state_next.resp_data  = set_cond[cmd_set];
				end
				SER_OP_READ_EN: begin
					state_next.resp_valid = 1'b1;
					state_next.resp_data  = set_enables[cmd_set];
				end
				SER_OP_NONE: begin
					state_next.resp_valid = 1'b0;
				end
				// writes, clear and preset change state but give no answer
				SER_OP_WRITE_EN, SER_OP_CLEAR, SER_OP_PRESET: begin
					state_next.resp_valid = 1'b0;
				end
				// the completion query answers later, once nothing pends
				SER_OP_OPC_QUERY: begin
					state_next.resp_valid = 1'b0;
				end
			endcase
		end
		if (opc_fire) begin
			state_next.resp_valid = 1'b1;
			state_next.resp_data  = `SER_OPC_REPLY;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg             <= '0;
			// power-up leaves a pending power-cycle event
			state_reg.pon_pending <= 1'b1;
			state_reg.intlk_meta  <= 1'b1;
			state_reg.intlk_sync  <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign resp_valid       = state_reg.resp_valid;
	assign resp_data        = state_reg.resp_data;
	assign summary          = state_reg.summary;
	assign source_on_permit = state_reg.source_permit;

endmodule : ser_top

`default_nettype wire

/* File: inc/ser_regs.svh */
// status event registers: bit positions, used-bit masks, reset values and counts
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

`define SER_STD_USED_MASK   16'h00FD
`define SER_OPER_USED_MASK  16'h0469
`define SER_MEAS_USED_MASK  16'h7FFF
`define SER_QUES_USED_MASK  16'h4100

`define SER_STD_OPC_BIT     0
`define SER_STD_EMPTY_BIT   2
`define SER_STD_INTF_BIT    3
`define SER_STD_EXEF_BIT    4
`define SER_STD_CMDF_BIT    5
`define SER_STD_LKEY_BIT    6
`define SER_STD_PWR_BIT     7

`define SER_OPER_CAL_BIT    0
`define SER_OPER_SWEEP_BIT  3
`define SER_OPER_TRIG_BIT   5
`define SER_OPER_ARM_BIT    6
`define SER_OPER_IDLE_BIT   10

`define SER_MEAS_LIM1_BIT   0
`define SER_MEAS_LL2_BIT    1
`define SER_MEAS_HL2_BIT    2
`define SER_MEAS_LL3_BIT    3
`define SER_MEAS_HL3_BIT    4
`define SER_MEAS_PASS_BIT   5
`define SER_MEAS_RDY_BIT    6
`define SER_MEAS_RANGE_BIT  7
`define SER_MEAS_BUF2_BIT   8
`define SER_MEAS_FULL_BIT   9
`define SER_MEAS_CONT_BIT   10
`define SER_MEAS_SAFE_BIT   11
`define SER_MEAS_THERM_BIT  12
`define SER_MEAS_SLIM_BIT   13
`define SER_MEAS_CLAMP_BIT  14

`define SER_QUES_CAL_BIT    8
`define SER_QUES_WARN_BIT   14

`define SER_EVENT_RESET     16'h0000
`define SER_ENABLE_RESET    16'h0000
`define SER_COND_RESET      16'h0000
`define SER_BUF_TWO         2
`define SER_OPC_REPLY       16'h0001

`endif

/* File: inc/ser_pkg.sv */
// status event registers: command, set and state types
`default_nettype none

package ser_pkg;

	typedef enum logic [2:0] {
		SER_OP_NONE      = 3'h0,
		SER_OP_READ_EVT  = 3'h1,
		SER_OP_READ_COND = 3'h2,
		SER_OP_WRITE_EN  = 3'h3,
		SER_OP_READ_EN   = 3'h4,
		SER_OP_CLEAR     = 3'h5,
		SER_OP_PRESET    = 3'h6,
		SER_OP_OPC_QUERY = 3'h7
	} ser_op_t;

	typedef enum logic [1:0] {
		SER_SET_STD  = 2'h0,
		SER_SET_OPER = 2'h1,
		SER_SET_MEAS = 2'h2,
		SER_SET_QUES = 2'h3
	} ser_set_sel_t;

	typedef struct packed {
		logic [15:0] event_bits;
		logic [15:0] enable_bits;
		logic [15:0] cond_prev;
	} ser_set_state_t;

	typedef struct packed {
		logic        intlk_meta;
		logic        intlk_sync;
		logic        key_meta;
		logic        key_sync;
		logic        key_prev;
		logic        pon_pending;
		logic        opc_armed;
		logic        cal_invalid;
		logic [15:0] oper_cond;
		logic [15:0] meas_cond;
		logic [15:0] ques_cond;
		logic        resp_valid;
		logic [15:0] resp_data;
		logic [3:0]  summary;
		logic        source_permit;
	} ser_top_state_t;

endpackage : ser_pkg

`default_nettype wire

/* File: hdl/ser_set.sv */
// status event registers: one event register set with its enable register
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"

module ser_set
	import ser_pkg::*;
#(
	parameter logic [15:0] USED_MASK = 16'hFFFF
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// event sources
	input  wire logic [15:0] cond,
	input  wire logic [15:0] evt,
	// register commands
	input  wire logic        read_clr,
	input  wire logic        clear_status,
	input  wire logic        preset,
	input  wire logic        enable_wr,
	input  wire logic [15:0] enable_data,
	// register contents
	output logic [15:0]      event_bits,
	output logic [15:0]      enable_bits
);

	ser_set_state_t state_reg;
	ser_set_state_t state_next;
	logic [15:0]    set_bits;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next          = state_reg;
		state_next.cond_prev = cond;
		set_bits = ((cond & ~state_reg.cond_prev) | evt) & USED_MASK;
		// a set in the clearing cycle survives, so no event is lost
		if (read_clr || clear_status) begin
			state_next.event_bits = set_bits;
		end else begin
			state_next.event_bits = state_reg.event_bits | set_bits;
		end
		if (preset) begin
			state_next.enable_bits = `SER_ENABLE_RESET;
		end else if (enable_wr) begin
			state_next.enable_bits = enable_data & USED_MASK;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '{event_bits: `SER_EVENT_RESET, enable_bits: `SER_ENABLE_RESET,
				cond_prev: `SER_COND_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign event_bits  = state_reg.event_bits;
	assign enable_bits = state_reg.enable_bits;

endmodule : ser_set

`default_nettype wire

/* File: verif/ser_properties.sv */
// status event registers: concurrent checks on the top module's ports
`timescale 1ns/1ps
`default_nettype none
`include "ser_regs.svh"

module ser_properties
	import ser_pkg::*;
(
	// clock and reset
	input wire logic         clock,
	input wire logic         rst,
	// command and answer
	input wire logic         cmd_valid,
	input wire ser_op_t      cmd_op,
	input wire ser_set_sel_t cmd_set,
	input wire logic         resp_valid,
	input wire logic [15:0]  resp_data,
	// sources and gate
	input wire logic         ops_pending,
	input wire logic         thermal_fault,
	input wire logic         interlock_n_pin,
	input wire logic         source_on_permit
);
	// ----
	// helper state
	// ----
	logic        opc_wait_reg;
	logic [15:0] mask_reg;
	logic        rd_cmd;

	assign rd_cmd = cmd_valid && (cmd_op == SER_OP_READ_EVT || cmd_op == SER_OP_READ_COND
		|| cmd_op == SER_OP_READ_EN);

	// a read holds off the opc answer a cycle; read data checks skip while one is outstanding
	always_ff @(posedge clock) begin
		if (rst)
			opc_wait_reg <= 1'b0;
		else if (cmd_valid && cmd_op == SER_OP_OPC_QUERY)
			opc_wait_reg <= 1'b1;
		else if (!ops_pending)
			opc_wait_reg <= 1'b0;
		case (cmd_set)
			SER_SET_STD:  mask_reg <= `SER_STD_USED_MASK;
			SER_SET_OPER: mask_reg <= `SER_OPER_USED_MASK;
			SER_SET_MEAS: mask_reg <= `SER_MEAS_USED_MASK;
			default:      mask_reg <= `SER_QUES_USED_MASK;
		endcase
	end

	// ----
	// assertions
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_preset_read;
		!opc_wait_reg && cmd_valid && cmd_op == SER_OP_PRESET ##1 !cmd_valid
			##1 cmd_valid && cmd_op == SER_OP_READ_EN;
	endsequence

	chk_read_answer: assert property (rd_cmd |=> resp_valid)
		else $error("read command got no answer");
	chk_std_no_cond: assert property (rd_cmd && cmd_op == SER_OP_READ_COND
		&& cmd_set == SER_SET_STD && !opc_wait_reg |=> resp_data == 16'h0000)
		else $error("standard set returned a condition value");
	chk_unused_zero: assert property (rd_cmd && !opc_wait_reg
		|=> (resp_data & ~mask_reg) == 16'h0000)
		else $error("unused bit read as one");
	chk_opc_held: assert property (opc_wait_reg && ops_pending && !cmd_valid
		|=> !resp_valid)
		else $error("completion answered while operations pending");
	chk_opc_answer: assert property (opc_wait_reg && !ops_pending
		|-> ##[1:2] (resp_valid && resp_data == `SER_OPC_REPLY))
		else $error("completion answer missing");
	chk_hot_blocks: assert property (thermal_fault |=> !source_on_permit)
		else $error("source permitted while overheated");
	chk_interlock_open: assert property (interlock_n_pin [*3] |=> !source_on_permit)
		else $error("source permitted with interlock open");
	chk_permit_ok: assert property ((!interlock_n_pin && !thermal_fault) [*3]
		|=> source_on_permit)
		else $error("source not permitted with interlock closed");
	chk_preset_enables: assert property (s_preset_read |=> resp_valid
		&& resp_data == 16'h0000)
		else $error("enable not zero after preset");
endmodule : ser_properties

bind ser_top ser_properties u_props (.*);
`default_nettype wire

/* File: verif/ser_host_model.sv */
// status event registers: host controller issuing status commands
`timescale 1ns/1ps
`default_nettype none

module ser_host_model
	import ser_pkg::*;
(
	// clock
	input wire logic        clock,
	// command port
	output ser_op_t         cmd_op,
	output ser_set_sel_t    cmd_set,
	output logic            cmd_valid,
	output logic [15:0]     cmd_data,
	// answer
	input wire logic        resp_valid,
	input wire logic [15:0] resp_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = SER_OP_NONE;
		cmd_set = SER_SET_STD;
		cmd_data = 16'h0000;
	end

	// ----
	// one query per call, dropped the edge after it is taken
	// ----
	task automatic send(input ser_op_t op, input ser_set_sel_t s, input logic [15:0] d);
		@(posedge clock);
		#1;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_set = s;
		cmd_data = d;
		@(posedge clock);
		#1;
		cmd_valid = 1'b0;
		cmd_op = SER_OP_NONE;
		cmd_data = ~d; // stale data is never left looking valid
	endtask : send

	task automatic wait_resp(input int lim, output logic [15:0] got, output bit ok);
		ok = 1'b0;
		got = 16'h0000;
		for (int i = 0; i < lim && !ok; i++) begin
			if (resp_valid === 1'b1) begin
				ok = 1'b1;
				got = resp_data;
			end else begin
				@(posedge clock);
				#1;
			end
		end
	endtask : wait_resp
endmodule : ser_host_model
`default_nettype wire

/* File: verif/status_event_registers_test.sv */
// status event registers: self-checking testbench
`timescale 1ns/1ps
`default_nettype none

module status_event_registers_test;
	import ser_pkg::*;
	logic clock, rst, cmd_valid, resp_valid, ops_pending, talk_read, out_queue_empty;
	logic internal_fault, execution_fault, syntax_fault, semantic_fault, trigger_in_message;
	logic local_key_pin, cal_busy, sweep_active, wait_trigger, wait_arm, idle_state;
	logic limit_one_fail, lower_bound_two_fail, upper_bound_two_fail, lower_bound_three_fail;
	logic upper_bound_three_fail, limits_all_pass, reading_ready, range_exceeded;
	logic trace_store_full, contact_check_fail, interlock_n_pin, thermal_fault;
	logic source_limited, source_clamped, cal_check_fail, cal_done_ok;
	logic ignored_parameter_notice, source_on_permit;
	ser_op_t      cmd_op;
	ser_set_sel_t cmd_set;
	logic [15:0]  cmd_data, resp_data, got;
	logic [11:0]  buffer_count;
	logic [3:0]   summary;
	bit           ok;
	int           fail_count, total_checks;
	logic [15:0]  std_exp [6] = '{16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0020, 16'h0020};

	ser_top #(.BUF_CNT_W(12)) u_dut (.*);
	ser_host_model u_host (.*);

	initial clock = 1'b0;
	always #20 clock = ~clock;

	// ----
	// shared tasks
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic summarize();
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask : chk

	task automatic rd(input ser_op_t op, input ser_set_sel_t s, input logic [15:0] exp);
		u_host.send(op, s, 16'h0000);
		u_host.wait_resp(8, got, ok);
		if (!ok) begin
			chk("answer", 16'h0000, 16'h0001);
			summarize();
		end
		chk($sformatf("%s %s", op.name(), s.name()), got, exp);
	endtask : rd

	// ----
	// main sequence
	// ----
	initial begin
		{ops_pending, talk_read, out_queue_empty, internal_fault, execution_fault} = '0;
		{syntax_fault, semantic_fault, trigger_in_message, local_key_pin, cal_busy} = '0;
		{sweep_active, wait_trigger, wait_arm, idle_state, cal_check_fail, cal_done_ok} = '0;
		{limit_one_fail, lower_bound_two_fail, upper_bound_two_fail, lower_bound_three_fail,
			upper_bound_three_fail, limits_all_pass, reading_ready, range_exceeded,
			trace_store_full, contact_check_fail, thermal_fault, source_limited,
			source_clamped, ignored_parameter_notice} = '0;
		buffer_count = 12'h000;
		interlock_n_pin = 1'b1;
		rst = 1'b1;
		tick(6);
		rst = 1'b0;
		tick(4);
		rd(SER_OP_READ_EVT, SER_SET_STD, 16'h0080);
		rd(SER_OP_READ_EVT, SER_SET_STD, 16'h0000);
		// read with data waiting must not flag an empty queue
		talk_read = 1'b1;
		tick(1);
		talk_read = 1'b0;
		rd(SER_OP_READ_EVT, SER_SET_STD, 16'h0000);
		out_queue_empty = 1'b1;
		for (int k = 0; k < 6; k++) begin
			{talk_read, internal_fault, execution_fault, syntax_fault, semantic_fault,
				trigger_in_message} = 6'h20 >> k;
			tick(1);
			{talk_read, internal_fault, execution_fault, syntax_fault, semantic_fault,
				trigger_in_message} = 6'h00;
			tick(2);
			rd(SER_OP_READ_EVT, SER_SET_STD, std_exp[k]);
		end
		local_key_pin = 1'b1;
		tick(4);
		local_key_pin = 1'b0;
		rd(SER_OP_READ_EVT, SER_SET_STD, 16'h0040);
		ops_pending = 1'b1;
		u_host.send(SER_OP_OPC_QUERY, SER_SET_STD, 16'h0000);
		u_host.wait_resp(6, got, ok);
		chk("opc early", {15'h0000, ok}, 16'h0000);
		ops_pending = 1'b0;
		u_host.wait_resp(6, got, ok);
		chk("opc reply", got, 16'h0001);
		if (!ok) summarize();
		rd(SER_OP_READ_EVT, SER_SET_STD, 16'h0001);
		{cal_busy, sweep_active, wait_trigger, wait_arm, idle_state} = 5'h1F;
		tick(4);
		rd(SER_OP_READ_COND, SER_SET_OPER, 16'h0469);
		rd(SER_OP_READ_EVT, SER_SET_OPER, 16'h0469);
		idle_state = 1'b0;
		tick(3);
		rd(SER_OP_READ_COND, SER_SET_OPER, 16'h0069);
		rd(SER_OP_READ_EVT, SER_SET_OPER, 16'h0000);
		{limit_one_fail, lower_bound_two_fail, upper_bound_two_fail, lower_bound_three_fail,
			upper_bound_three_fail, limits_all_pass, reading_ready, range_exceeded,
			trace_store_full, contact_check_fail, thermal_fault, source_limited,
			source_clamped} = '1;
		buffer_count = 12'h001;
		interlock_n_pin = 1'b0;
		tick(5);
		rd(SER_OP_READ_COND, SER_SET_MEAS, 16'h7EFF);
		chk("permit hot", {15'h0000, source_on_permit}, 16'h0000);
		thermal_fault = 1'b0;
		buffer_count = 12'h002;
		tick(4);
		rd(SER_OP_READ_COND, SER_SET_MEAS, 16'h6FFF);
		chk("permit", {15'h0000, source_on_permit}, 16'h0001);
		rd(SER_OP_READ_EVT, SER_SET_MEAS, 16'h7FFF);
		u_host.send(SER_OP_WRITE_EN, SER_SET_MEAS, 16'hFFFF);
		rd(SER_OP_READ_EN, SER_SET_MEAS, 16'h7FFF);
		for (int k = 0; k < 2; k++) begin
			reading_ready = 1'b0;
			tick(2);
			reading_ready = 1'b1;
			tick(4);
			chk("summary", {12'h000, summary}, 16'h0004);
			if (k == 0) begin
				u_host.send(SER_OP_CLEAR, SER_SET_STD, 16'h0000);
				tick(3);
				chk("summary clr", {12'h000, summary}, 16'h0000);
				rd(SER_OP_READ_EN, SER_SET_MEAS, 16'h7FFF);
			end
		end
		u_host.send(SER_OP_PRESET, SER_SET_STD, 16'h0000);
		rd(SER_OP_READ_EN, SER_SET_MEAS, 16'h0000);
		rd(SER_OP_READ_EVT, SER_SET_MEAS, 16'h0040);
		cal_check_fail = 1'b1;
		tick(1);
		cal_check_fail = 1'b0;
		ignored_parameter_notice = 1'b1;
		tick(1);
		ignored_parameter_notice = 1'b0;
		tick(3);
		rd(SER_OP_READ_COND, SER_SET_QUES, 16'h0100);
		rd(SER_OP_READ_EVT, SER_SET_QUES, 16'h4100);
		cal_done_ok = 1'b1;
		tick(1);
		cal_done_ok = 1'b0;
		tick(3);
		rd(SER_OP_READ_COND, SER_SET_QUES, 16'h0000);
		rd(SER_OP_READ_COND, SER_SET_STD, 16'h0000);
		u_host.send(SER_OP_WRITE_EN, SER_SET_STD, 16'hFFFF);
		rd(SER_OP_READ_EN, SER_SET_STD, 16'h00FD);
		internal_fault = 1'b1;
		tick(1);
		internal_fault = 1'b0;
		tick(2);
		chk("summary std", {12'h000, summary}, 16'h0001);
		rd(SER_OP_READ_EVT, SER_SET_STD, 16'h0008);
		tick(1);
		chk("summary read", {12'h000, summary}, 16'h0000);
		summarize();
	end
endmodule : status_event_registers_test
`default_nettype wire
